// >>> bcme_core.sv
// sequencer for jumps, calls, return and byte copies
// assumes program memory answers code_data combinationally for code_addr
`default_nettype none

module bcme_core
   import bcme_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // program memory
   output logic [15:0] code_addr,
   input wire logic [7:0] code_data,
   // port latch
   output logic [7:0] port_zero_out,
   // status
   output logic instr_done,
   output logic illegal_opcode
);

   ////////////////////////////////////////////////////////////////////////
   // instruction length from the opcode byte
   function automatic logic [1:0] op_length(input logic [7:0] op);
      logic [1:0] len;
      len = LEN_ONE;
      if (op == OP_LONG_JUMP || op == OP_LONG_CALL)
         len = LEN_THREE;
      else if (op == OP_COPY_DIR_IMM || op == OP_COPY_DIR_DIR)
         len = LEN_THREE;
      else if (op == OP_SHORT_JUMP)
         len = LEN_TWO;
      else if (op[4:0] == OP_BLOCK_JUMP_LOW || op[4:0] == OP_BLOCK_CALL_LOW)
         len = LEN_TWO;
      else if (op == OP_COPY_ACC_IMM || op == OP_COPY_ACC_DIR || op == OP_COPY_DIR_ACC)
         len = LEN_TWO;
      else if (op[7:3] == OP_COPY_REG_IMM_HI)
         len = LEN_TWO;
      return len;
   endfunction : op_length

   // copy opcodes this sequencer executes, a subset of the full copy family
   function automatic logic is_copy(input logic [7:0] op);
      return (op == OP_COPY_ACC_IMM) || (op == OP_COPY_DIR_IMM) ||
             (op == OP_COPY_ACC_DIR) || (op == OP_COPY_DIR_ACC) ||
             (op == OP_COPY_DIR_DIR) || (op[7:3] == OP_COPY_REG_IMM_HI) ||
             (op[7:3] == OP_COPY_ACC_REG_HI) || (op[7:3] == OP_COPY_REG_ACC_HI);
   endfunction : is_copy

   ////////////////////////////////////////////////////////////////////////
   // state
   bcme_state_t state_reg, state_next;
   logic [15:0] pc_reg, pc_next;
   logic [7:0] opcode_reg, opcode_next;
   logic [7:0] oper1_reg, oper1_next;
   logic [7:0] oper2_reg, oper2_next;
   logic [7:0] data_reg, data_next;
   logic [15:0] target_reg, target_next;
   logic done_reg, done_next;
   logic illegal_reg, illegal_next;

   bcme_data_if dbus ();

   bcme_data_mem u_data_mem
   (
      .clock(clock),
      .rst(rst),
      .dbus(dbus.mem),
      .port_zero(port_zero_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // opcode class decode
   wire [7:0] op = opcode_reg;
   wire is_long_jump = (op == OP_LONG_JUMP);
   wire is_short_jump = (op == OP_SHORT_JUMP);
   wire is_block_jump = (op[4:0] == OP_BLOCK_JUMP_LOW);
   wire is_long_call = (op == OP_LONG_CALL);
   wire is_block_call = (op[4:0] == OP_BLOCK_CALL_LOW);
   wire is_return = (op == OP_RETURN);
   wire is_copy_op = is_copy(op);
   wire [1:0] fetch_len = op_length(code_data);
   wire [1:0] cur_len = op_length(opcode_reg);
   wire [15:0] pc_inc = pc_reg + 16'h0001;

   // working register address in bank zero
   wire [7:0] reg_addr = {5'h00, op[2:0]};

   ////////////////////////////////////////////////////////////////////////
   // branch targets; pc_reg already points past the operands here
   wire [15:0] long_target = {oper1_reg, oper2_reg};
   wire [15:0] rel_offset = {{8{oper1_reg[7]}}, oper1_reg};
   wire [15:0] short_target = pc_reg + rel_offset;
   wire [15:0] block_target = {pc_reg[15:BLOCK_BITS], op[7:5], oper1_reg};
   wire [15:0] call_target = is_long_call ? long_target : block_target;

   ////////////////////////////////////////////////////////////////////////
   // copy operand selection
   // the working register source only feeds the accumulator, so no
   // register to register path exists
   wire src_is_dir = (op == OP_COPY_ACC_DIR) || (op == OP_COPY_DIR_DIR);
   wire src_is_reg = (op[7:3] == OP_COPY_ACC_REG_HI);
   wire src_is_acc = (op == OP_COPY_DIR_ACC) || (op[7:3] == OP_COPY_REG_ACC_HI);
   wire [7:0] src_addr = src_is_reg ? reg_addr : oper1_reg;
   wire [7:0] imm_byte = (op == OP_COPY_DIR_IMM) ? oper2_reg : oper1_reg;
   wire [7:0] src_byte = src_is_acc ? dbus.acc :
                         (src_is_dir || src_is_reg) ? dbus.rdata : imm_byte;

   // destination: first operand, taken from the second operand byte for a direct-to-direct copy
   wire dst_is_acc = (op == OP_COPY_ACC_IMM) || (op == OP_COPY_ACC_DIR) ||
                     (op[7:3] == OP_COPY_ACC_REG_HI);
   wire dst_is_reg = (op[7:3] == OP_COPY_REG_IMM_HI) || (op[7:3] == OP_COPY_REG_ACC_HI);
   wire [7:0] dst_addr = dst_is_acc ? SFR_ACC :
                         dst_is_reg ? reg_addr :
                         (op == OP_COPY_DIR_DIR) ? oper2_reg : oper1_reg;

   ////////////////////////////////////////////////////////////////////////
   // stack addressing; the stack grows upward, two bytes per call
   wire [7:0] sp_plus1 = dbus.sp + 8'h01;
   wire [7:0] sp_plus2 = dbus.sp + CALL_STACK_BYTES;
   wire [7:0] sp_minus1 = dbus.sp - 8'h01;
   wire [7:0] sp_minus2 = dbus.sp - CALL_STACK_BYTES;

   // data port drive per state
   wire st_exec = (state_reg == ST_EXEC);
   wire st_write = (state_reg == ST_WRITE);
   wire st_push_lo = (state_reg == ST_PUSH_LO);
   wire st_push_hi = (state_reg == ST_PUSH_HI);
   wire st_pop_hi = (state_reg == ST_POP_HI);
   wire st_pop_lo = (state_reg == ST_POP_LO);

   assign dbus.addr = st_write ? dst_addr :
                      st_push_lo ? sp_plus1 :
                      st_push_hi ? sp_plus2 :
                      st_pop_hi ? dbus.sp :
                      st_pop_lo ? sp_minus1 : src_addr;
   assign dbus.wdata = st_push_lo ? pc_reg[7:0] :
                       st_push_hi ? pc_reg[15:8] : data_reg;
   assign dbus.we = st_write || st_push_lo || st_push_hi;
   assign dbus.indirect = st_push_lo || st_push_hi || st_pop_hi || st_pop_lo;
   assign dbus.sp_load = st_push_hi || st_pop_lo;
   assign dbus.sp_wdata = st_push_hi ? sp_plus2 : sp_minus2;

   assign code_addr = pc_reg;
   assign instr_done = done_reg;
   assign illegal_opcode = illegal_reg;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      state_next = state_reg;
      pc_next = pc_reg;
      opcode_next = opcode_reg;
      oper1_next = oper1_reg;
      oper2_next = oper2_reg;
      data_next = data_reg;
      target_next = target_reg;
      done_next = 1'b0;
      illegal_next = 1'b0;
      case (state_reg)
         ST_FETCH:
         begin
            opcode_next = code_data;
            pc_next = pc_inc;
            state_next = (fetch_len == LEN_ONE) ? ST_EXEC : ST_OPER1;
         end
         ST_OPER1:
         begin
            oper1_next = code_data;
            pc_next = pc_inc;
            state_next = (cur_len == LEN_THREE) ? ST_OPER2 : ST_EXEC;
         end
         ST_OPER2:
         begin
            oper2_next = code_data;
            pc_next = pc_inc;
            state_next = ST_EXEC;
         end
         ST_EXEC:
         begin
            state_next = ST_FETCH;
            done_next = 1'b1;
            if (is_long_jump)
               pc_next = long_target;
            else if (is_short_jump)
               pc_next = short_target;
            else if (is_block_jump)
               pc_next = block_target;
            else if (is_long_call || is_block_call)
            begin
               // return address first, target loaded only after both pushes
               target_next = call_target;
               done_next = 1'b0;
               state_next = ST_PUSH_LO;
            end
            else if (is_return)
            begin
               done_next = 1'b0;
               state_next = ST_POP_HI;
            end
            else if (is_copy_op)
            begin
               // source is latched so a direct-to-direct copy needs one port
               data_next = src_byte;
               done_next = 1'b0;
               state_next = ST_WRITE;
            end
            else if (op != 8'h00)
               illegal_next = 1'b1;
         end
         ST_WRITE:
         begin
            done_next = 1'b1;
            state_next = ST_FETCH;
         end
         ST_PUSH_LO:
            state_next = ST_PUSH_HI;
         ST_PUSH_HI:
         begin
            pc_next = target_reg;
            done_next = 1'b1;
            state_next = ST_FETCH;
         end
         ST_POP_HI:
         begin
            target_next = {dbus.rdata, target_reg[7:0]};
            state_next = ST_POP_LO;
         end
         ST_POP_LO:
         begin
            pc_next = {target_reg[15:8], dbus.rdata};
            done_next = 1'b1;
            state_next = ST_FETCH;
         end
         default:
            state_next = ST_FETCH;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg <= ST_FETCH;
         pc_reg <= PC_RESET;
         done_reg <= 1'b0;
         illegal_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         done_reg <= done_next;
         illegal_reg <= illegal_next;
      end
   end

   // datapath registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         opcode_reg <= 8'h00;
         oper1_reg <= 8'h00;
         oper2_reg <= 8'h00;
         data_reg <= 8'h00;
         target_reg <= 16'h0000;
      end
      else
      begin
         opcode_reg <= opcode_next;
         oper1_reg <= oper1_next;
         oper2_reg <= oper2_next;
         data_reg <= data_next;
         target_reg <= target_next;
      end
   end

endmodule : bcme_core

`default_nettype wire

// >>> bcme_pkg.sv
// shared constants for the branch, call and copy execution block
// assumes a single core clock and an external byte-wide program memory
`default_nettype none

package bcme_pkg;

   // opcodes handled by this block
   localparam logic [7:0] OP_LONG_JUMP = 8'h02;
   localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
   localparam logic [7:0] OP_LONG_CALL = 8'h12;
   localparam logic [7:0] OP_RETURN = 8'h22;
   localparam logic [4:0] OP_BLOCK_JUMP_LOW = 5'h01;
   localparam logic [4:0] OP_BLOCK_CALL_LOW = 5'h11;
   localparam logic [7:0] OP_COPY_ACC_IMM = 8'h74;
   localparam logic [7:0] OP_COPY_DIR_IMM = 8'h75;
   localparam logic [7:0] OP_COPY_ACC_DIR = 8'he5;
   localparam logic [7:0] OP_COPY_DIR_ACC = 8'hf5;
   localparam logic [7:0] OP_COPY_DIR_DIR = 8'h85;
   localparam logic [4:0] OP_COPY_REG_IMM_HI = 5'h0f;
   localparam logic [4:0] OP_COPY_ACC_REG_HI = 5'h1d;
   localparam logic [4:0] OP_COPY_REG_ACC_HI = 5'h1f;

   // opcode space figures
   localparam int COPY_ENCODINGS = 57;
   localparam int DEFINED_OPCODES = 254;

   // special function register addresses
   localparam logic [7:0] SFR_PORT_ZERO = 8'h80;
   localparam logic [7:0] SFR_STACK_PTR = 8'h81;
   localparam logic [7:0] SFR_ACC = 8'he0;
   localparam logic [7:0] SFR_BASE = 8'h80;

   // reset values
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] PORT_ZERO_RESET = 8'hff;
   localparam logic [7:0] SFR_RESET = 8'h00;

   // addressing geometry
   localparam int BLOCK_BITS = 11;
   localparam int SHORT_BACK = 128;
   localparam int SHORT_FWD = 127;
   localparam logic [7:0] CALL_STACK_BYTES = 8'h02;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // execution sequencer states
   typedef enum logic [3:0]
   {
      ST_FETCH,
      ST_OPER1,
      ST_OPER2,
      ST_EXEC,
      ST_WRITE,
      ST_PUSH_LO,
      ST_PUSH_HI,
      ST_POP_HI,
      ST_POP_LO
   } bcme_state_t;

endpackage : bcme_pkg

`default_nettype wire

// >>> bcme_data_if.sv
// data-side port between the sequencer and the data memory unit
// assumes both ends run on the same core clock
`default_nettype none

interface bcme_data_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic we;
   logic indirect;
   logic [7:0] rdata;
   logic [7:0] acc;
   logic [7:0] sp;
   logic sp_load;
   logic [7:0] sp_wdata;

   modport core
   (
      output addr, wdata, we, indirect, sp_load, sp_wdata,
      input rdata, acc, sp
   );

   modport mem
   (
      input addr, wdata, we, indirect, sp_load, sp_wdata,
      output rdata, acc, sp
   );
endinterface : bcme_data_if

`default_nettype wire

// >>> bcme_data_mem.sv
// internal RAM and special function register space for the sequencer
// assumes single-cycle writes and combinational reads on the data port
`default_nettype none

module bcme_data_mem
   import bcme_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // sequencer side
   bcme_data_if.mem dbus,
   // port latch
   output logic [7:0] port_zero
);

   logic [7:0] ram [256];
   logic [7:0] sfr_file [128];
   logic [7:0] acc_reg;
   logic [7:0] sp_reg;
   logic [7:0] port_zero_reg;

   ////////////////////////////////////////////////////////////////////////
   // decode: stack traffic is indirect and may reach the upper RAM half
   wire is_sfr = !dbus.indirect && (dbus.addr >= SFR_BASE);
   wire ram_we = dbus.we && !is_sfr;
   wire sfr_we = dbus.we && is_sfr;
   wire [6:0] sfr_idx = dbus.addr[6:0];
   wire [7:0] sfr_rd = (dbus.addr == SFR_ACC) ? acc_reg :
                       (dbus.addr == SFR_STACK_PTR) ? sp_reg :
                       (dbus.addr == SFR_PORT_ZERO) ? port_zero_reg : sfr_file[sfr_idx];

   // direct source read from RAM or register space
   assign dbus.rdata = is_sfr ? sfr_rd : ram[dbus.addr];
   assign dbus.acc = acc_reg;
   assign dbus.sp = sp_reg;
   assign port_zero = port_zero_reg;

   ////////////////////////////////////////////////////////////////////////
   // storage arrays carry no reset
   always_ff @(posedge clock)
   begin
      if (ram_we)
         ram[dbus.addr] <= dbus.wdata;
      if (sfr_we)
         sfr_file[sfr_idx] <= dbus.wdata;
   end

   // named registers; a stack pointer load beats a direct write to it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         acc_reg <= ACC_RESET;
         sp_reg <= SP_RESET;
         port_zero_reg <= PORT_ZERO_RESET;
      end
      else
      begin
         if (sfr_we && dbus.addr == SFR_ACC)
            acc_reg <= dbus.wdata;
         if (dbus.sp_load)
            sp_reg <= dbus.sp_wdata;
         else if (sfr_we && dbus.addr == SFR_STACK_PTR)
            sp_reg <= dbus.wdata;
         if (sfr_we && dbus.addr == SFR_PORT_ZERO)
            port_zero_reg <= dbus.wdata;
      end
   end

endmodule : bcme_data_mem

`default_nettype wire

// >>> bcme_core_props.sv
// checker for jumps, calls, return and port copies seen at the core's pins
// assumes combinational program memory and that instr_done marks the next fetch
`default_nettype none

module bcme_core_props
   import bcme_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // program memory
   input wire logic [15:0] code_addr,
   input wire logic [7:0] code_data,
   // outputs
   input wire logic [7:0] port_zero_out,
   input wire logic instr_done,
   input wire logic illegal_opcode
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   logic rst_d;
   logic at_fetch;
   logic [15:0] addr_inc;

   // fetch is known only after reset or a completed instruction; every opcode, nops and undefined ones included, ends with instr_done
   assign at_fetch = (rst_d && !rst) || instr_done;
   assign addr_inc = code_addr + 16'h0001;

   // remembers reset to spot the first fetch
   always_ff @(posedge clock)
   begin
      rst_d <= rst;
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   reset_state_a: assert property (disable iff (1'b0) rst |=>
      code_addr == PC_RESET && port_zero_out == PORT_ZERO_RESET && !instr_done && !illegal_opcode)
      else $error("outputs not at reset state");
   done_pulse_a: assert property (instr_done |=> !instr_done)
      else $error("instr_done longer than one cycle");
   long_jump_a: assert property (at_fetch && code_data == OP_LONG_JUMP |->
      ##4 instr_done && code_addr == {$past(code_data, 3), $past(code_data, 2)}) else $error("long jump wrong");
   short_jump_a: assert property (at_fetch && code_data == OP_SHORT_JUMP |-> ##3 instr_done &&
      code_addr == $past(addr_inc, 2) + {{8{$past(code_data[7], 2)}}, $past(code_data, 2)})
      else $error("short jump wrong");
   block_jump_a: assert property (at_fetch && code_data[4:0] == OP_BLOCK_JUMP_LOW |-> ##3 instr_done &&
      code_addr == {$past(addr_inc[15:11], 2), $past(code_data[7:5], 3), $past(code_data, 2)})
      else $error("block jump wrong");
   long_call_a: assert property (at_fetch && code_data == OP_LONG_CALL |->
      ##6 instr_done && code_addr == {$past(code_data, 5), $past(code_data, 4)}) else $error("long call wrong");
   block_call_a: assert property (at_fetch && code_data[4:0] == OP_BLOCK_CALL_LOW |-> ##5 instr_done &&
      code_addr == {$past(addr_inc[15:11], 4), $past(code_data[7:5], 5), $past(code_data, 4)})
      else $error("block call wrong");
   return_time_a: assert property (at_fetch && code_data == OP_RETURN |->
      ##1 !instr_done [*3] ##1 instr_done) else $error("return timing wrong");
   port_copy_a: assert property (at_fetch && code_data == OP_COPY_DIR_IMM ##1 code_data == SFR_PORT_ZERO |->
      ##4 instr_done && port_zero_out == $past(code_data, 3)) else $error("port copy wrong");
   port_change_a: assert property ($changed(port_zero_out) |-> instr_done)
      else $error("port changed outside a copy");

   // main scenarios
   cover property (at_fetch && code_data == OP_LONG_CALL);
   cover property (at_fetch && code_data == OP_RETURN);
   cover property (illegal_opcode);
   cover property ($changed(port_zero_out));

endmodule : bcme_core_props

bind bcme_core bcme_core_props u_props (.clock(clock), .rst(rst), .code_addr(code_addr), .code_data(code_data),
   .port_zero_out(port_zero_out), .instr_done(instr_done), .illegal_opcode(illegal_opcode));

`default_nettype wire

// >>> bcme_prog_mem.sv
// byte-wide program memory model facing the core's fetch port
// assumes the bench lays programs down hierarchically while the core is in reset
`default_nettype none

module bcme_prog_mem
(
   // fetch side
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [0:65535];

   // cleared to nops so stray fetches stay harmless
   initial
   begin
      for (int a = 0; a < 65536; a++)
         mem[a] = 8'h00;
   end

   // zero-latency read, as the core samples in the same cycle
   assign code_data = mem[code_addr];

endmodule : bcme_prog_mem

`default_nettype wire

// >>> test_branch_call_move_execution.sv
// testbench for jumps, calls, return and copies run from program memory
// assumes the checker is bound to the core; observes only pc, port latch and pulses
`default_nettype none

module test_branch_call_move_execution;
   timeunit 1ns;
   timeprecision 1ps;
   import bcme_pkg::*;

   localparam logic AT_PC = 1'b0;
   localparam logic AT_PORT = 1'b1;
   logic clock;
   logic rst;
   logic [15:0] code_addr;
   logic [7:0] code_data;
   logic [7:0] port_zero_out;
   logic instr_done;
   logic illegal_opcode;
   int miscompares;
   int checks;
   int refusals;

   bcme_core DUT (.clock(clock), .rst(rst), .code_addr(code_addr), .code_data(code_data),
      .port_zero_out(port_zero_out), .instr_done(instr_done), .illegal_opcode(illegal_opcode));
   bcme_prog_mem pmem (.code_addr(code_addr), .code_data(code_data));

   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task end_sim();
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
      foreach (b[i])
         pmem.mem[a + 16'(i)] = b[i];
   endtask : put

   // programs are laid down under reset so the core starts cleanly at 0000h
   task hold();
      @(posedge clock);
      #1 rst = 1'b1;
      refusals = 0;
   endtask : hold

   task release_core();
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
   endtask : release_core

   // a hang shows as an unknown, which never matches
   task expect_after(input logic on_port, input logic [15:0] exp);
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         #1 n++;
      end
      while (instr_done !== 1'b1 && n < 40);
      check(n < 40 ? (on_port ? {8'h00, port_zero_out} : code_addr) : 16'hxxxx, exp);
   endtask : expect_after

   ////////////////////////////////////////////////////////////////////////////////
   // the first scenario's hold and release add three edges, six under reset in all
   task s_reset();
      repeat (3) @(posedge clock);
      #1 check(code_addr, PC_RESET);
      check({8'h00, port_zero_out}, {8'h00, PORT_ZERO_RESET});
      check({15'h0000, instr_done}, 16'h0000);
   endtask : s_reset

   task s_long_jump();
      hold();
      put(16'h0000, '{8'h02, 8'h24, 8'h00});
      put(16'h2400, '{8'h75, 8'h80, 8'h5a, 8'h80, 8'hfe});
      release_core();
      expect_after(AT_PC, 16'h2400);
      expect_after(AT_PORT, 16'h005a);
      check(code_addr, 16'h2403);
   endtask : s_long_jump

   // both reach limits of the relative range
   task s_short_jump();
      hold();
      put(16'h0000, '{8'h02, 8'h01, 8'h00});
      put(16'h0100, '{8'h80, 8'h80});
      put(16'h0082, '{8'h80, 8'h7f});
      put(16'h0103, '{8'h80, 8'hfe});
      release_core();
      expect_after(AT_PC, 16'h0100);
      expect_after(AT_PC, 16'h0082);
      expect_after(AT_PC, 16'h0103);
   endtask : s_short_jump

   // jumps that straddle a block edge take the block of the following byte
   task s_block_jump();
      hold();
      put(16'h0000, '{8'h02, 8'h07, 8'hfe});
      put(16'h07fe, '{8'he1, 8'hff});
      put(16'h0fff, '{8'h21, 8'h23});
      put(16'h1123, '{8'h80, 8'hfe});
      release_core();
      expect_after(AT_PC, 16'h07fe);
      expect_after(AT_PC, 16'h0fff);
      expect_after(AT_PC, 16'h1123);
   endtask : s_block_jump

   // nested calls; the subroutines copy the stack pointer and stacked bytes to the port
   task s_calls();
      hold();
      put(16'h0000, '{8'h12, 8'h30, 8'h00, 8'h11, 8'h50, 8'h80, 8'hfe});
      put(16'h3000, '{8'h85, 8'h81, 8'h80, 8'h12, 8'h00, 8'h50, 8'h85, 8'h0a, 8'h80, 8'h85, 8'h0b, 8'h80, 8'h22});
      put(16'h0050, '{8'h85, 8'h81, 8'h80, 8'h85, 8'h08, 8'h80, 8'h22});
      release_core();
      expect_after(AT_PC, 16'h3000);
      expect_after(AT_PORT, 16'h0009);
      expect_after(AT_PC, 16'h0050);
      expect_after(AT_PORT, 16'h000b);
      expect_after(AT_PORT, 16'h0003);
      expect_after(AT_PC, 16'h3006);
      expect_after(AT_PORT, 16'h0006);
      expect_after(AT_PORT, 16'h0030);
      expect_after(AT_PC, 16'h0003);
      expect_after(AT_PC, 16'h0050);
      expect_after(AT_PORT, 16'h0009);
      expect_after(AT_PORT, 16'h0005);
      expect_after(AT_PC, 16'h0005);
   endtask : s_calls

   // every working register goes through the accumulator on its way to the port,
   // then the accumulator is copied back into a register
   task s_copy();
      hold();
      put(16'h0000, '{8'h74, 8'h3c, 8'hf5, 8'h80, 8'h75, 8'h40, 8'ha5, 8'he5, 8'h40, 8'hf5, 8'h80});
      for (int r = 0; r < 8; r++)
      begin
         put(16'h000b + 16'(2 * r), '{8'h78 + 8'(r), 8'h90 + 8'(r)});
         put(16'h001b + 16'(3 * r), '{8'he8 + 8'(r), 8'hf5, 8'h80});
      end
      put(16'h0033, '{8'h74, 8'h5c, 8'hf8, 8'h85, 8'h00, 8'h80, 8'h80, 8'hfe});
      release_core();
      expect_after(AT_PC, 16'h0002);
      expect_after(AT_PORT, 16'h003c);
      expect_after(AT_PORT, 16'h003c);
      expect_after(AT_PC, 16'h0009);
      expect_after(AT_PORT, 16'h00a5);
      for (int r = 0; r < 8; r++)
         expect_after(AT_PC, 16'h000d + 16'(2 * r));
      for (int r = 0; r < 8; r++)
      begin
         expect_after(AT_PC, 16'h001c + 16'(3 * r));
         expect_after(AT_PORT, 16'h0090 + 16'(r));
      end
      expect_after(AT_PC, 16'h0035);
      expect_after(AT_PC, 16'h0036);
      expect_after(AT_PORT, 16'h005c);
   endtask : s_copy

   // a nop and an undefined opcode are each skipped as one byte
   task s_refuse();
      hold();
      put(16'h0000, '{8'h00, 8'ha5, 8'h74, 8'h11, 8'hf5, 8'h80, 8'h80, 8'hfe});
      release_core();
      for (int n = 0; n < 60 && port_zero_out !== 8'h11; n++)
      begin
         @(posedge clock);
         #1;
      end
      check({8'h00, port_zero_out}, 16'h0011);
      check(16'(refusals), 16'h0001);
   endtask : s_refuse

   ////////////////////////////////////////////////////////////////////////////////
   // free-running core clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // counts refusal pulses for the current program
   always @(posedge clock)
   begin
      if (illegal_opcode === 1'b1)
         refusals++;
   end

   // the whole run needs well under a thousand cycles
   initial
   begin
      #100000;
      miscompares++;
      end_sim();
   end

   initial
   begin
      rst = 1'b1;
      miscompares = 0;
      checks = 0;
      refusals = 0;
      s_reset();
      s_long_jump();
      s_short_jump();
      s_block_jump();
      s_calls();
      s_copy();
      s_refuse();
      end_sim();
   end

endmodule : test_branch_call_move_execution

`default_nettype wire
